// ===== hdl/report_builder_pkg.sv
`default_nettype none
package report_builder_pkg;
  // ----------------------------------------------------------------
  // Report layout
  // ----------------------------------------------------------------
  localparam int REPORT_BYTES = 11;
  localparam logic [7:0] REPORT_LENGTH_LO = 8'h0b;
  localparam logic [7:0] REPORT_LENGTH_HI = 8'h00;
  localparam logic [3:0] BYTE_LENGTH_LO = 4'h0;
  localparam logic [3:0] BYTE_LENGTH_HI = 4'h1;
  localparam logic [3:0] BYTE_REPORT_ID = 4'h2;
  localparam logic [3:0] BYTE_MODIFIERS = 4'h3;
  localparam logic [3:0] BYTE_RESERVED = 4'h4;
  localparam logic [3:0] BYTE_FIRST_KEY = 4'h5;
  localparam logic [3:0] BYTE_LAST_KEY = 4'ha;
  localparam int KEY_SLOTS = 6;
  localparam logic [7:0] USAGE_MOD_FIRST = 8'he0;
  localparam logic [7:0] USAGE_MOD_LAST = 8'he7;
  localparam logic [7:0] USAGE_NONE = 8'h00;

  // Modifier flag positions in the modifier byte
  localparam int MODIFIER_FLAG_LCTL = 0;
  localparam int MODIFIER_FLAG_LSHF = 1;
  localparam int MODIFIER_FLAG_LALT = 2;
  localparam int MODIFIER_FLAG_LWIN = 3;
  localparam int MODIFIER_FLAG_RCTL = 4;
  localparam int MODIFIER_FLAG_RSHF = 5;
  localparam int MODIFIER_FLAG_RALT = 6;
  localparam int MODIFIER_FLAG_RWIN = 7;

  // ----------------------------------------------------------------
  // Register map (10-bit address, 8-bit data)
  // ----------------------------------------------------------------
  localparam logic [9:0] ADDR_KEYMAP_BASE = 10'h000;
  localparam logic [9:0] ADDR_KEYMAP_LAST = 10'h07f;
  localparam logic [9:0] ADDR_REPORT_ID = 10'h202;
  localparam logic [9:0] ADDR_STATUS = 10'h300;
  localparam logic [9:0] ADDR_MASK = 10'h301;
  localparam logic [9:0] ADDR_STATE = 10'h302;
  localparam logic [7:0] RESET_REPORT_ID = 8'h01;
  localparam logic [7:0] RESET_MASK = 8'h00;
  localparam int STATUS_REPORT_DONE = 0;
  localparam int STATUS_KEY_DROPPED = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOKUP = 2'b01,
    ST_APPLY = 2'b10,
    ST_SEND = 2'b11
  } builder_state_type;
endpackage
`default_nettype wire

// ===== hdl/key_map_memory.sv
`default_nettype none
// Keyboard map: one usage code per key position, registered read
module key_map_memory #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Write port; contents are programmed by software, no reset
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data comes out of a register one cycle after the address
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ===== hdl/keyboard_input_report_builder.sv
// Behaviour
// [RL1] Up to six held ordinary keys, one usage code each, in bytes 5 to 10.
// [RL2] Usage E0..E7 set modifier flags in byte 3, bit 0 left control.
// [RL3] Bytes 0 and 1 hold little-endian length 11.
// [RL4] Byte 2 holds the report identifier; byte 4 stays reserved zero.
// [RL5] A report is produced on every key press and every key release.
// [RL6] With no key held, report is zero except length and identifier.
// [RL7] Modifier-only changes also produce reports.
// [RL8] Usage code per key position comes from the keyboard map memory.
// [RL9] Identifier byte carries the default identifier held at 0202h.
// [RL10] Host reads the input report with a plain read, no address first.
// [RL11] Slots fill in detection order; unused slots read zero.
`default_nettype none
module keyboard_input_report_builder
  import report_builder_pkg::*;
#(
  parameter int KEY_POSITIONS = 128,
  parameter int POS_W = 7
) (
  input wire logic clk,
  input wire logic rst,
  // Key events from the matrix scanner
  input wire logic key_event_valid,
  output logic key_event_ready,
  input wire logic key_event_press,
  input wire logic [POS_W-1:0] key_event_pos,
  // Report byte stream towards the host link
  output logic report_valid,
  input wire logic report_ready,
  output logic [7:0] report_byte,
  output logic report_last,
  // Register port
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic irq
);
  builder_state_type state_q;
  logic press_q;
  logic [POS_W-1:0] pos_q;
  logic [7:0] usage;
  logic [7:0] modifiers_q;
  logic [7:0] slot_q [KEY_SLOTS];
  logic [2:0] count_q;
  logic [3:0] byte_idx_q;
  logic [7:0] report_id_q;
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic [7:0] rdata_q;
  logic [7:0] byte_q;
  logic is_modifier;
  logic [2:0] hit_idx;
  logic hit;
  logic map_wr;
  logic send_step;
  logic report_done;
  logic key_dropped;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One report byte by its index
  function automatic logic [7:0] report_field(input logic [3:0] idx);
    logic [7:0] r;
    r = 8'h00;
    if (idx == BYTE_LENGTH_LO) begin
      r = REPORT_LENGTH_LO; // [RL3]
    end else if (idx == BYTE_LENGTH_HI) begin
      r = REPORT_LENGTH_HI; // [RL3]
    end else if (idx == BYTE_REPORT_ID) begin
      r = report_id_q; // [RL4] [RL9]
    end else if (idx == BYTE_MODIFIERS) begin
      r = modifiers_q; // [RL2] [RL7]
    end else if (idx == BYTE_RESERVED) begin
      r = 8'h00; // [RL4]
    end else if (idx >= BYTE_FIRST_KEY && idx <= BYTE_LAST_KEY) begin
      r = slot_q[3'(idx - BYTE_FIRST_KEY)]; // [RL1] [RL6]
    end
    return r;
  endfunction

  // True when the address falls inside the keyboard map
  function automatic logic in_keymap(input logic [9:0] a);
    return (a >= ADDR_KEYMAP_BASE) && (a <= ADDR_KEYMAP_LAST);
  endfunction

  // ----------------------------------------------------------------
  // Keyboard map lookup
  // ----------------------------------------------------------------
  assign map_wr = reg_write && in_keymap(reg_addr);

  key_map_memory #(
    .DEPTH(KEY_POSITIONS),
    .AW(POS_W)
  ) u_map (
    .clk(clk),
    .wr_en(map_wr),
    .wr_addr(reg_addr[POS_W-1:0]),
    .wr_data(reg_wdata),
    .rd_addr(pos_q),
    .rd_data(usage)
  ); // [RL8]

  // Modifier range test and search of the held keys
  always_comb begin
    is_modifier = (usage >= USAGE_MOD_FIRST) && (usage <= USAGE_MOD_LAST);
    hit = 1'b0;
    hit_idx = 3'd0;
    for (int i = KEY_SLOTS - 1; i >= 0; i--) begin
      if (3'(i) < count_q && slot_q[i] == usage) begin
        hit = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign key_event_ready = (state_q == ST_IDLE);
  assign report_valid = (state_q == ST_SEND);
  assign send_step = report_valid && report_ready;
  assign report_last = report_valid && (byte_idx_q == BYTE_LAST_KEY);
  assign report_byte = byte_q;
  assign report_done = send_step && (byte_idx_q == BYTE_LAST_KEY);

  // Event accept, lookup, apply, then send one report
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (key_event_valid) begin
            state_q <= ST_LOOKUP;
          end
        end
        ST_LOOKUP: begin
          state_q <= ST_APPLY;
        end
        ST_APPLY: begin
          state_q <= ST_SEND; // [RL5]
        end
        ST_SEND: begin
          if (report_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Captured event
  always_ff @(posedge clk) begin
    if (rst) begin
      press_q <= 1'b0;
      pos_q <= '0;
    end else if (key_event_valid && key_event_ready) begin
      press_q <= key_event_press;
      pos_q <= key_event_pos;
    end
  end

  // ----------------------------------------------------------------
  // Held key state
  // ----------------------------------------------------------------
  // Modifier flags follow the mapped usage code
  always_ff @(posedge clk) begin
    if (rst) begin
      modifiers_q <= 8'h00;
    end else if (state_q == ST_APPLY && is_modifier) begin
      modifiers_q[usage[2:0]] <= press_q; // [RL2] [RL7]
    end
  end

  // Slots: append on press, remove and close the gap on release
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= 3'd0;
      for (int i = 0; i < KEY_SLOTS; i++) begin
        slot_q[i] <= USAGE_NONE;
      end
    end else if (state_q == ST_APPLY && !is_modifier
                 && usage != USAGE_NONE) begin
      if (press_q && !hit && count_q < 3'(KEY_SLOTS)) begin
        slot_q[count_q] <= usage; // [RL11] [RL1]
        count_q <= count_q + 3'd1;
      end else if (!press_q && hit) begin
        // Close the gap: slots above the hit move down one place
        for (int i = 0; i < KEY_SLOTS - 1; i++) begin
          if (3'(i) >= hit_idx) begin
            slot_q[i] <= slot_q[i+1]; // [RL11]
          end
        end
        // The top slot frees up on every release of a held key
        slot_q[KEY_SLOTS-1] <= USAGE_NONE; // [RL11] [RL6]
        count_q <= count_q - 3'd1;
      end
    end
  end

  assign key_dropped = state_q == ST_APPLY && !is_modifier && press_q
                       && usage != USAGE_NONE && !hit
                       && count_q == 3'(KEY_SLOTS);

  // ----------------------------------------------------------------
  // Report serialiser
  // ----------------------------------------------------------------
  // Byte index walks 0..10 while the host takes bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      byte_idx_q <= BYTE_LENGTH_LO;
    end else if (state_q == ST_APPLY || report_done) begin
      byte_idx_q <= BYTE_LENGTH_LO;
    end else if (send_step) begin
      byte_idx_q <= byte_idx_q + 4'd1;
    end
  end

  // Output byte register, loaded with the byte about to be offered
  always_ff @(posedge clk) begin
    if (rst) begin
      byte_q <= 8'h00;
    end else if (state_q == ST_APPLY) begin
      byte_q <= REPORT_LENGTH_LO; // [RL3]
    end else if (send_step && !report_done) begin
      byte_q <= report_field(byte_idx_q + 4'd1); // [RL10]
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Default report identifier
  always_ff @(posedge clk) begin
    if (rst) begin
      report_id_q <= RESET_REPORT_ID;
    end else if (reg_write && reg_addr == ADDR_REPORT_ID) begin
      report_id_q <= reg_wdata; // [RL9]
    end
  end

  // Interrupt mask
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= RESET_MASK;
    end else if (reg_write && reg_addr == ADDR_MASK) begin
      mask_q <= reg_wdata;
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (reg_write && reg_addr == ADDR_STATUS && reg_wdata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
      if (report_done) begin
        status_q[STATUS_REPORT_DONE] <= 1'b1;
      end
      if (key_dropped) begin
        status_q[STATUS_KEY_DROPPED] <= 1'b1;
      end
    end
  end

  assign irq = |(status_q & mask_q);

  // Read data appear the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_read) begin
      if (reg_addr == ADDR_REPORT_ID) begin
        rdata_q <= report_id_q;
      end else if (reg_addr == ADDR_STATUS) begin
        rdata_q <= status_q;
      end else if (reg_addr == ADDR_MASK) begin
        rdata_q <= mask_q;
      end else if (reg_addr == ADDR_STATE) begin
        rdata_q <= {3'b000, state_q, count_q};
      end else begin
        rdata_q <= 8'h00; // Keyboard map is write-only; unmapped reads 0
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// ===== verification/report_stream_checker_sva.sv
`default_nettype none
module report_stream_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic key_event_valid,
  input wire logic key_event_ready,
  input wire logic report_valid,
  input wire logic report_ready,
  input wire logic [7:0] report_byte,
  input wire logic report_last,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Byte position tracking and properties
  // ----------------------------------------------------------------
  logic [3:0] idx_q;
  // Position of the offered byte within its report
  always_ff @(posedge clk) begin
    if (rst) begin
      idx_q <= 4'h0;
    end else if (report_valid && report_ready) begin
      idx_q <= report_last ? 4'h0 : idx_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_take;
    key_event_valid && key_event_ready;
  endsequence
  sequence s_busy;
    !key_event_ready && !report_valid;
  endsequence
  property p_answer;
    s_take |=> s_busy [*2] ##1 report_valid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("report not offered three edges after event");
  property p_len_lo;
    report_valid && idx_q == 4'h0 |-> report_byte == 8'h0b;
  endproperty
  a_len_lo: assert property (p_len_lo)
    else $error("length low byte wrong");
  property p_len_hi;
    report_valid && idx_q == 4'h1 |-> report_byte == 8'h00;
  endproperty
  a_len_hi: assert property (p_len_hi)
    else $error("length high byte wrong");
  property p_rsvd;
    report_valid && idx_q == 4'h4 |-> report_byte == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved byte not zero");
  property p_last;
    report_valid |-> report_last == (idx_q == 4'ha);
  endproperty
  a_last: assert property (p_last)
    else $error("last flag not on byte ten");
  property p_hold;
    report_valid && !report_ready |=> report_valid && $stable(report_byte);
  endproperty
  a_hold: assert property (p_hold)
    else $error("byte changed while stalled");
  property p_done;
    report_valid && report_ready && report_last |=>
      !report_valid && key_event_ready;
  endproperty
  a_done: assert property (p_done)
    else $error("stream not closed after last byte");
  property p_rdata;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside its cycle");
endmodule
bind keyboard_input_report_builder report_stream_checker u_chk (
  .clk(clk), .rst(rst), .key_event_valid(key_event_valid),
  .key_event_ready(key_event_ready), .report_valid(report_valid),
  .report_ready(report_ready), .report_byte(report_byte),
  .report_last(report_last), .reg_read(reg_read), .reg_rdata(reg_rdata)
);
`default_nettype wire

// ===== verification/host_report_reader.sv
`default_nettype none
module host_report_reader (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic report_valid,
  output logic report_ready,
  input wire logic [7:0] report_byte,
  input wire logic report_last,
  output logic [87:0] rpt,
  output int nrep
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx;
  // Drain bytes with no address phase, stalling every other cycle if slow
  always_ff @(posedge clk) begin
    if (rst) begin
      report_ready <= 1'b0;
      idx <= 0;
      nrep <= 0;
    end else begin
      report_ready <= slow ? ~report_ready : 1'b1;
      if (report_valid && report_ready) begin
        rpt[8*idx +: 8] <= report_byte;
        idx <= report_last ? 0 : idx + 1;
        nrep <= nrep + (report_last ? 1 : 0);
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/test_keyboard_input_report_builder.sv
`default_nettype none
module test_keyboard_input_report_builder;
  import report_builder_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic key_event_valid = 1'b0;
  logic key_event_press = 1'b0;
  logic [6:0] key_event_pos = 7'h00;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic slow = 1'b0;
  logic key_event_ready, report_valid, report_ready, report_last, irq;
  logic [7:0] report_byte, reg_rdata, rid, mods;
  logic [87:0] rpt;
  logic [7:0] held[$];
  int nrep, i;
  int fail_count = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  keyboard_input_report_builder dut (.clk(clk), .rst(rst),
    .key_event_valid(key_event_valid), .key_event_ready(key_event_ready),
    .key_event_press(key_event_press), .key_event_pos(key_event_pos),
    .report_valid(report_valid), .report_ready(report_ready),
    .report_byte(report_byte), .report_last(report_last),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
  host_report_reader host (.clk(clk), .rst(rst), .slow(slow),
    .report_valid(report_valid), .report_ready(report_ready),
    .report_byte(report_byte), .report_last(report_last), .rpt(rpt),
    .nrep(nrep));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", what, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
    @(posedge clk);
  endtask
  function automatic logic [7:0] usage(input logic [6:0] p);
    return p < 7'h08 ? 8'h04 + {1'b0, p} : 8'hd8 + {1'b0, p};
  endfunction
  // Send one event, update the expected state, compare the whole report
  task automatic evt(input logic pr, input logic [6:0] p);
    logic [7:0] u;
    logic hit;
    logic rdy;
    int n0;
    int k;
    u = usage(p);
    n0 = nrep;
    hit = 1'b0;
    key_event_valid <= 1'b1;
    key_event_press <= pr;
    key_event_pos <= p;
    // Hold the event until the builder is seen ready at an edge
    rdy = 1'b0;
    for (k = 0; k < 300 && !rdy; k++) begin
      @(negedge clk);
      rdy = key_event_ready;
      @(posedge clk);
    end
    key_event_valid <= 1'b0;
    for (k = held.size() - 1; k >= 0; k--) begin
      if (held[k] == u) begin
        hit = 1'b1;
        if (!pr) held.delete(k);
      end
    end
    if (u >= USAGE_MOD_FIRST && u <= USAGE_MOD_LAST) begin
      mods[u[2:0]] = pr;
    end else if (pr && !hit && held.size() < KEY_SLOTS) begin
      held.push_back(u);
    end
    for (k = 0; k < 300 && nrep == n0; k++) begin
      @(posedge clk);
      #1;
    end
    if (nrep == n0) begin
      $display("[ERR] report expected 1 seen 0");
      fail_count++;
      end_of_test;
    end else begin
      chk("len_lo", 8'h0b, rpt[7:0]);
      chk("len_hi", 8'h00, rpt[15:8]);
      chk("report_id", rid, rpt[23:16]);
      chk("modifiers", mods, rpt[31:24]);
      chk("reserved", 8'h00, rpt[39:32]);
      for (k = 0; k < KEY_SLOTS; k++) begin
        chk("key_slot", k < held.size() ? held[k] : 8'h00,
            rpt[40+8*k +: 8]);
      end
      @(posedge clk);
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rid = 8'h01;
    mods = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 16; i++) wr(10'(i), usage(7'(i)));
    rd(ADDR_REPORT_ID, 8'h01);
    rid = 8'h05;
    wr(ADDR_REPORT_ID, rid);
    rd(ADDR_REPORT_ID, rid);
    rd(10'h3ff, 8'h00);
    wr(ADDR_MASK, 8'h01);
    $display("test registers done");
    for (i = 0; i < 7; i++) evt(1'b1, 7'(i));
    evt(1'b1, 7'h03);
    rd(ADDR_STATE, 8'h06);
    chk("irq", 8'h01, {7'h00, irq});
    rd(ADDR_STATUS, 8'h03);
    wr(ADDR_STATUS, 8'h03);
    rd(ADDR_STATUS, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    $display("test press done");
    slow <= 1'b1;
    evt(1'b0, 7'h02);
    evt(1'b0, 7'h00);
    for (i = 1; i < 7; i++) evt(1'b0, 7'(i));
    slow <= 1'b0;
    rd(ADDR_STATE, 8'h00);
    $display("test release done");
    for (i = 8; i < 16; i++) evt(1'b1, 7'(i));
    for (i = 8; i < 16; i++) evt(1'b0, 7'(i));
    $display("test modifiers done");
    end_of_test;
  end
endmodule
`default_nettype wire
